// ===== common/rrx_defines.svh
`ifndef RRX_DEFINES_SVH
`define RRX_DEFINES_SVH
// instruction word width and opcodes (values chosen for this core)
`define RRX_IW 14
`define RRX_OP_RESET 14'h0001
`define RRX_OP_IRET 14'h0009
`define RRX_OP_RETURN 14'h0008
`define RRX_OP_LRET_HI 6'h34
// field positions
`define RRX_IEN_BIT 7
`define RRX_LIT_MSB 7
`define RRX_OPHI_MSB 13
`define RRX_OPHI_LSB 8
// timing
`define RRX_RET_CYCLES 2'h2
// reset values
`define RRX_PWRCTL_RST 8'h04
`define RRX_RI_BIT 2
`endif

// ===== common/rrx_pkg.sv
package rrx_pkg;
  typedef enum logic [2:0] {
    RRX_IDLE = 3'b001,
    RRX_RET2 = 3'b010,
    RRX_RST = 3'b100
  } rrx_state_type;

  typedef enum logic [3:0] {
    RRX_K_NONE = 4'b0000,
    RRX_K_RST = 4'b0001,
    RRX_K_RFI = 4'b0010,
    RRX_K_RET = 4'b0100,
    RRX_K_RLW = 4'b1000
  } rrx_kind_type;

  typedef struct packed {
    logic valid;
    logic [13:0] word;
  } rrx_instr_type;

  typedef struct packed {
    logic pop;
    logic pc_load;
    logic w_load;
    logic gie_set;
    logic flags_hold;
  } rrx_ctl_type;
endpackage : rrx_pkg

// ===== hw/rrx_decode.sv
`timescale 1ns/1ps
`include "rrx_defines.svh"
// pure opcode classification of one fetched word
module rrx_decode
  import rrx_pkg::*;
(
  input wire logic [`RRX_IW-1:0] word_i, // fetched instruction word
  output rrx_kind_type kind_o // class of the word
);
  wire logic is_rst = (word_i == `RRX_OP_RESET);
  wire logic is_rfi = (word_i == `RRX_OP_IRET);
  wire logic is_ret = (word_i == `RRX_OP_RETURN);
  wire logic is_rlw =
    (word_i[`RRX_OPHI_MSB:`RRX_OPHI_LSB] == `RRX_OP_LRET_HI);
  // unknown words fall to none; the rest of the core handles them
  assign kind_o = is_rst ? RRX_K_RST :
                  is_rfi ? RRX_K_RFI :
                  is_ret ? RRX_K_RET :
                  is_rlw ? RRX_K_RLW : RRX_K_NONE;
endmodule : rrx_decode

// ===== hw/rrx_exec.sv
`timescale 1ns/1ps
`include "rrx_defines.svh"
// Contract
// - reset instruction resets device, clears flag
// - interrupt return sets global interrupt enable
// - interrupt return pops stack, two cycles
// - subroutine return pops stack into PC
// - literal return loads literal into W
// - literal return reloads PC, two cycles
module rrx_exec
  import rrx_pkg::*;
#(
  parameter int PC_W = 13,
  parameter int DEPTH = 16,
  parameter int PTR_W = 4
) (
  input wire logic sys_clk_i, // core clock
  input wire logic arst_n_i, // async reset, active low
  input wire logic instr_valid_i, // fetched word is present
  input wire logic [`RRX_IW-1:0] instr_i, // fetched word
  input wire logic push_i, // call or interrupt pushes
  input wire logic [PC_W-1:0] push_addr_i, // return address to push
  input wire logic [7:0] status_i, // arithmetic flags in
  output logic busy_o, // second cycle of a return
  output logic [PC_W-1:0] pc_o, // program counter
  output logic pc_load_o, // pc reloaded this cycle
  output logic [7:0] w_o, // working register
  output logic global_interrupt_enable_o, // interrupt enable copy
  output logic [7:0] interrupt_control_register_o, // interrupt control
  output logic [7:0] power_control_register_o, // power control
  output logic soft_reset_o, // device reset request
  output logic [7:0] status_o // flags out, held by these ops
);
  // ****************************************
  // reset release
  // ****************************************
  logic rst_s1_q;
  logic rst_n_q;
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // ****************************************
  // decode
  // ****************************************
  rrx_kind_type kind;
  rrx_decode u_dec (
    .word_i(instr_i),
    .kind_o(kind)
  );

  rrx_state_type state_q;
  rrx_state_type state_d;
  logic [1:0] cyc_q;
  logic [PC_W-1:0] stack_q [DEPTH];
  logic [PTR_W-1:0] sp_q;
  logic [7:0] ictl_q;
  logic [7:0] pctl_q;

  // new instructions are only taken while idle
  wire logic take = instr_valid_i && (state_q == RRX_IDLE);
  wire logic do_rst = take && (kind == RRX_K_RST);
  wire logic do_pop = take && ((kind == RRX_K_RFI) ||
    (kind == RRX_K_RET) || (kind == RRX_K_RLW));
  // top of stack is the entry just below the pointer
  wire logic [PTR_W-1:0] sp_top = sp_q - {{(PTR_W-1){1'b0}}, 1'b1};
  wire logic [PC_W-1:0] stack_top_value = stack_q[sp_top];
  wire logic [PC_W-1:0] pc_inc = pc_o + {{(PC_W-1){1'b0}}, 1'b1};

  // ****************************************
  // state machine
  // ****************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      RRX_IDLE: begin
        if (do_rst) begin
          state_d = RRX_RST;
        end else if (do_pop) begin
          state_d = RRX_RET2;
        end
      end
      RRX_RET2: begin
        if (cyc_q == `RRX_RET_CYCLES - 2'h1) begin
          state_d = RRX_IDLE;
        end
      end
      RRX_RST: state_d = RRX_IDLE;
      default: state_d = RRX_IDLE;
    endcase
  end

  // cycle count within a two-cycle return
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= RRX_IDLE;
      cyc_q <= 2'h0;
    end else begin
      state_q <= state_d;
      cyc_q <= do_pop ? 2'h1 : 2'h0;
    end
  end

  // ****************************************
  // return stack; wraps on overflow
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sp_q <= '0;
    end else if (soft_reset_o) begin
      sp_q <= '0;
    end else if (do_pop) begin
      sp_q <= sp_top;
    end else if (push_i) begin
      sp_q <= sp_q + {{(PTR_W-1){1'b0}}, 1'b1};
    end
  end

  // stack contents need no reset; empty slots are never read legally
  always_ff @(posedge sys_clk_i) begin
    if (push_i && !do_pop) begin
      stack_q[sp_q] <= push_addr_i;
    end
  end

  // ****************************************
  // program counter and working register
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pc_o <= '0;
      pc_load_o <= 1'b0;
    end else if (soft_reset_o) begin
      pc_o <= '0;
      pc_load_o <= 1'b1;
    end else if (do_pop) begin
      pc_o <= stack_top_value;
      pc_load_o <= 1'b1;
    end else begin
      pc_o <= (take && kind == RRX_K_NONE) ? pc_inc : pc_o;
      pc_load_o <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      w_o <= 8'h00;
    end else if (take && kind == RRX_K_RLW) begin
      w_o <= instr_i[`RRX_LIT_MSB:0];
    end
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ictl_q <= 8'h00;
      pctl_q <= `RRX_PWRCTL_RST;
      soft_reset_o <= 1'b0;
    end else if (soft_reset_o) begin
      // device reset clears control state but keeps the cause record
      ictl_q <= 8'h00;
      soft_reset_o <= 1'b0;
    end else begin
      if (take && kind == RRX_K_RFI) begin
        ictl_q[`RRX_IEN_BIT] <= 1'b1;
      end
      if (do_rst) begin
        pctl_q[`RRX_RI_BIT] <= 1'b0;
        soft_reset_o <= 1'b1;
      end
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      busy_o <= 1'b0;
      status_o <= 8'h00;
      interrupt_control_register_o <= 8'h00;
      power_control_register_o <= `RRX_PWRCTL_RST;
      global_interrupt_enable_o <= 1'b0;
    end else begin
      busy_o <= do_pop;
      status_o <= status_i;
      interrupt_control_register_o <= ictl_q;
      power_control_register_o <= pctl_q;
      global_interrupt_enable_o <= ictl_q[`RRX_IEN_BIT];
    end
  end
endmodule : rrx_exec

// ===== dv/rrx_exec_monitor.sv
`timescale 1ns/1ps
`include "rrx_defines.svh"
module rrx_exec_monitor (
  input wire logic sys_clk_i, // clock
  input wire logic arst_n_i, // reset
  input wire logic instr_valid_i, // word present
  input wire logic [`RRX_IW-1:0] instr_i, // word
  input wire logic [7:0] status_i, // flags in
  input wire logic busy_o, // second cycle
  input wire logic pc_load_o, // pc reload
  input wire logic [7:0] w_o, // w
  input wire logic global_interrupt_enable_o, // interrupt enable
  input wire logic [7:0] power_control_register_o, // power control
  input wire logic soft_reset_o, // reset pulse
  input wire logic [7:0] status_o // flags out
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  // a word counts only outside busy and reset cycles
  wire tk = instr_valid_i && !busy_o && !soft_reset_o;
  wire lit = instr_i[`RRX_OPHI_MSB:`RRX_OPHI_LSB] == `RRX_OP_LRET_HI;
  a_rst_pulse: assert property (
    tk && instr_i == `RRX_OP_RESET |=> soft_reset_o) else $error("no rst");
  a_flag_clear: assert property (
    soft_reset_o |=> !power_control_register_o[`RRX_RI_BIT])
    else $error("flag kept");
  a_gie_set: assert property (
    tk && instr_i == `RRX_OP_IRET |=> ##1 global_interrupt_enable_o)
    else $error("enable low");
  a_rfi_load: assert property (
    tk && instr_i == `RRX_OP_IRET |=> pc_load_o && busy_o)
    else $error("rfi load");
  a_busy_one: assert property (busy_o |=> !busy_o)
    else $error("busy long");
  a_ret_load: assert property (
    tk && instr_i == `RRX_OP_RETURN |=> pc_load_o && busy_o)
    else $error("ret load");
  a_lit_w: assert property (
    tk && lit |=> w_o == $past(instr_i[`RRX_LIT_MSB:0])) else $error("w");
  a_lit_two: assert property (tk && lit |=> busy_o ##1 !busy_o)
    else $error("rlw len");
  a_flags_pass: assert property (
    $changed(status_i) |=> status_o == $past(status_i)) else $error("flags");
  c_rfi: cover property (tk && instr_i == `RRX_OP_IRET);
  c_lit: cover property (tk && lit);
  c_rst: cover property (soft_reset_o);
endmodule : rrx_exec_monitor
bind rrx_exec rrx_exec_monitor i_mon (.*);

// ===== dv/rrx_fetch_model.sv
`timescale 1ns/1ps
module rrx_fetch_model (
  input wire logic sys_clk_i, // core clock
  input wire logic busy_i, // core busy
  output logic valid_o, // word offered
  output logic [13:0] word_o // offered word
);
  int misses = 0;
  initial begin
    valid_o = 1'b0;
    word_o = 14'h0000;
  end
  // hold until an idle edge takes it; inverse after, never a stale word
  task automatic send(input logic [13:0] w);
    int n;
    n = 0;
    // one idle edge first so back-to-back calls never re-raise valid
    @(posedge sys_clk_i);
    #1;
    valid_o = 1'b1;
    word_o = w;
    while (busy_i && n < 4) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    if (busy_i) begin
      misses++;
    end
    @(posedge sys_clk_i);
    #1;
    valid_o = 1'b0;
    word_o = ~w;
  endtask : send
endmodule : rrx_fetch_model

// ===== dv/rrx_exec_tb_top.sv
`timescale 1ns/1ps
`include "rrx_defines.svh"
module rrx_exec_tb_top;
  logic sys_clk_i = 1'b0, arst_n_i = 1'b0, push_i = 1'b0;
  logic [12:0] push_addr_i = 13'h0000, pc_o;
  logic [7:0] status_i = 8'h00, w_o, status_o;
  logic [7:0] interrupt_control_register_o, power_control_register_o;
  logic instr_valid_i, busy_o, pc_load_o, soft_reset_o;
  logic global_interrupt_enable_o;
  logic [13:0] instr_i;
  int num_errors = 0, checks = 0;
  rrx_exec i_dut (.*);
  rrx_fetch_model i_fetch (.sys_clk_i, .busy_i(busy_o),
    .valid_o(instr_valid_i), .word_o(instr_i));
  always #5 sys_clk_i = ~sys_clk_i;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task tick;
    @(posedge sys_clk_i);
    #1;
  endtask : tick
  task push(input logic [12:0] a);
    push_i = 1'b1;
    push_addr_i = a;
    tick;
    push_i = 1'b0;
    tick;
  endtask : push
  // ****************
  // scenarios
  // ****************
  task t_ret;
    status_i = 8'h5a;
    push(13'h0123);
    push(13'h1abc);
    i_fetch.send(`RRX_OP_RETURN);
    chk(pc_o, 13'h1abc);
    chk(pc_load_o, 1'b1);
    i_fetch.send(`RRX_OP_RETURN);
    chk(pc_o, 13'h0123);
    chk(status_o, 8'h5a);
    $display("ret done");
  endtask : t_ret
  task t_rfi;
    push(13'h0777);
    chk(global_interrupt_enable_o, 1'b0);
    i_fetch.send(`RRX_OP_IRET);
    chk(pc_o, 13'h0777);
    tick;
    chk(busy_o, 1'b0);
    chk(global_interrupt_enable_o, 1'b1);
    chk(interrupt_control_register_o[7], 1'b1);
    $display("rfi done");
  endtask : t_rfi
  task t_rlw;
    logic [7:0] k[3] = '{8'h00, 8'hff, 8'h3c};
    foreach (k[i]) begin
      push({5'h04, k[i]});
      i_fetch.send({`RRX_OP_LRET_HI, k[i]});
      chk(w_o, k[i]);
      chk(pc_o, {5'h04, k[i]});
      tick;
      chk(busy_o, 1'b0);
    end
    $display("rlw done");
  endtask : t_rlw
  task t_rst;
    i_fetch.send(`RRX_OP_RESET);
    chk(soft_reset_o, 1'b1);
    tick;
    chk(power_control_register_o[`RRX_RI_BIT], 1'b0);
    tick;
    chk(pc_o, 13'h0000);
    $display("rst done");
  endtask : t_rst
  task results;
    num_errors += i_fetch.misses;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results
  // main sequence; the watchdog cuts any hang short
  initial begin
    repeat (12) @(posedge sys_clk_i);
    #1 arst_n_i = 1'b1;
    repeat (3) tick;
    chk(power_control_register_o, 8'h04);
    t_ret;
    t_rfi;
    t_rlw;
    t_rst;
    results;
  end
  initial begin
    #100000;
    num_errors++;
    results;
  end
endmodule : rrx_exec_tb_top
